// ### verilog/motion_pause_resume_current_ctl.sv
// Motion pause/resume, run current, current-off polarity and erase/copy command control
`timescale 1ns/1ns

// Functional notes
// - Resume finishes the remaining part of paused motion
// - Indexes resume toward the original target
// - Continuous moves resume in same direction
// - Home search restarts from its beginning
// - Resume uses profile values current at resume
// - Resume ignored when nothing is paused
// - Start input acts as resume during sequences
// - Motion-end wait holds while paused
// - Linked motion pause soft-stops; resumes ignored
// - Run current 5 to 100, default 100
// - Run current applies while accelerating, running, decelerating
// - Run current immediate and auto-saved
// - Current-off polarity 0 open, 1 closed
// - Polarity saved now, applied after reset
// - Erase-all clears parameters, positions and sequences
// - Position erase zeroes every table entry
// - Erase needs Y confirmation, else cancels
// - Sequence erase time scales with stored count
// - Copy sequence 0-63, keeps source, confirms overwrite
module motion_pause_resume_current_ctl
  import motion_ctl_pkg::*;
#(
  parameter int NUM_POS = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              pause_in,
  input  wire logic              start_in,
  input  wire logic              current_off_input,
  input  wire logic              motion_done,
  output logic                   motion_go,
  output logic      [2:0]        motion_kind,
  output logic                   motion_dir,
  output logic      [POS_W-1:0]  motion_target,
  output logic      [POS_W-1:0]  motion_remain,
  output logic                   soft_stop,
  output logic      [6:0]        drive_current,
  output logic                   current_cut,
  output logic                   nv_write,
  output logic                   motion_end_release
);

  reg_req_t   req;
  ctl_state_t state;
  motion_t    cur;
  profile_t   profile;
  profile_t   active_profile;
  logic [6:0] run_current_percent;
  logic       current_off_polarity;
  logic       polarity_active;
  logic       seq_running;
  logic       wait_motion_end;
  logic       resume_blocked;
  logic [3:0] pending_cmd;
  logic [5:0] seq_count;
  logic [63:0] seq_present;
  logic [15:0] erase_cnt;
  logic [15:0] nv_writes;
  logic [11:0] copy_ids;
  logic       copy_overwrite_ask;
  logic [POS_W-1:0] pos_table [NUM_POS];
  logic [2:0] pause_sync;
  logic [2:0] start_sync;
  logic [1:0] current_off_input_sync;
  logic       done_evt;
  logic       resume_evt;
  logic       pause_evt;
  logic [3:0] cmd;
  logic [7:0] key;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;
  assign cmd = req.wdata[CMD_LSB +: 4];
  assign key = req.wdata[7:0];

  // Pins pass two flip-flops; the third stage only feeds the edge detect
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pause_sync <= 3'h0;
      start_sync <= 3'h0;
      current_off_input_sync <= 2'h0;
    end else begin
      pause_sync <= {pause_sync[1:0], pause_in};
      start_sync <= {start_sync[1:0], start_in};
      current_off_input_sync <= {current_off_input_sync[0], current_off_input};
    end
  end

  wire cmd_wr = req.wr && (req.addr == REG_CMD);

  assign pause_evt  = (cmd_wr && cmd == CMD_PAUSE) || (pause_sync[1] && !pause_sync[2]);
  assign resume_evt = (cmd_wr && cmd == CMD_RESUME)
                    || (seq_running && start_sync[1] && !start_sync[2]);
  assign done_evt   = motion_done && (state == ST_MOVING);

  // Main command sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state          <= ST_IDLE;
      cur            <= '0;
      active_profile <= '0;
      motion_go      <= 1'b0;
      soft_stop      <= 1'b0;
      resume_blocked <= 1'b0;
      pending_cmd    <= 4'h0;
      erase_cnt      <= 16'h0000;
    end else begin
      motion_go <= 1'b0;
      soft_stop <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_wr && cmd == CMD_START_MOVE) begin
            cur.kind       <= move_kind_t'(req.wdata[CMD_ARG_LSB +: 3]);
            cur.dir        <= req.wdata[CMD_ARG_LSB + 3];
            cur.target     <= motion_target;
            cur.remain     <= motion_remain;
            active_profile <= profile;
            resume_blocked <= 1'b0;
            motion_go      <= 1'b1;
            state          <= ST_MOVING;
          end else if (cmd_wr && (cmd == CMD_ERASE_ALL || cmd == CMD_ERASE_POS
                                  || cmd == CMD_ERASE_SEQ)) begin
            pending_cmd <= cmd;
            state       <= ST_CONFIRM;
          end else if (resume_evt && resume_blocked) begin
            resume_blocked <= 1'b1;
          end
        end
        ST_MOVING: begin
          if (pause_evt) begin
            if (cur.kind == MOVE_LINKED) begin
              soft_stop      <= 1'b1;
              resume_blocked <= 1'b1;
              state          <= ST_IDLE;
            end else begin
              soft_stop <= 1'b1;
              cur.remain <= motion_remain;
              state     <= ST_PAUSED;
            end
          end else if (done_evt) begin
            state <= ST_IDLE;
          end
        end
        ST_PAUSED: begin
          if (resume_evt) begin
            active_profile <= profile;
            case (cur.kind)
              MOVE_HOME_POS, MOVE_HOME_NEG: cur.remain <= '0;
              MOVE_INC, MOVE_ABS: cur.target <= cur.target;
              MOVE_RESUME_COMMAND: cur.dir <= cur.dir;
              default: cur.remain <= cur.remain;
            endcase
            motion_go <= 1'b1;
            state     <= ST_MOVING;
          end else if (cmd_wr && cmd == CMD_DISCARD) begin
            cur.kind <= MOVE_NONE;
            state    <= ST_IDLE;
          end
        end
        ST_CONFIRM: begin
          if (req.wr && req.addr == REG_CONFIRM) begin
            if (key == KEY_YES_UC || key == KEY_YES_LC) begin
              erase_cnt <= (pending_cmd == CMD_ERASE_POS) ? 16'(ERASE_BASE_CYC)
                         : 16'(ERASE_BASE_CYC + ERASE_PER_SEQ * int'(seq_count));
              state     <= ST_ERASING;
            end else begin
              pending_cmd <= 4'h0;
              state       <= ST_IDLE;
            end
          end
        end
        ST_ERASING: begin
          if (erase_cnt == 16'h0000) begin
            pending_cmd <= 4'h0;
            state       <= ST_IDLE;
          end else begin
            erase_cnt <= erase_cnt - 16'h0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  wire erase_go = (state == ST_CONFIRM) && req.wr && (req.addr == REG_CONFIRM)
                  && (key == KEY_YES_UC || key == KEY_YES_LC);
  wire erase_params = erase_go && (pending_cmd == CMD_ERASE_ALL);
  wire erase_pos    = erase_go && (pending_cmd == CMD_ERASE_ALL || pending_cmd == CMD_ERASE_POS);
  wire erase_seq    = erase_go && (pending_cmd == CMD_ERASE_ALL || pending_cmd == CMD_ERASE_SEQ);

  // Motion-end wait releases on a move end, on a discard while paused, or on a new move start
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_motion_end    <= 1'b0;
      motion_end_release <= 1'b0;
    end else begin
      motion_end_release <= 1'b0;
      if (wait_motion_end && (done_evt || (state == ST_PAUSED && cmd_wr && cmd == CMD_DISCARD)
                              || (state == ST_IDLE && cmd_wr && cmd == CMD_START_MOVE))) begin
        wait_motion_end    <= 1'b0;
        motion_end_release <= 1'b1;
      end else if (cmd_wr && cmd == CMD_WAIT_END) begin
        wait_motion_end <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq_running <= 1'b0;
    end else if (cmd_wr && cmd == CMD_SEQ_RUN) begin
      seq_running <= 1'b1;
    end else if (cmd_wr && cmd == CMD_SEQ_STOP) begin
      seq_running <= 1'b0;
    end
  end

  // Out-of-range values are refused, so they never cost a nonvolatile write
  wire run_cur_ok = req.wr && (req.addr == REG_RUN_CUR) && (req.wdata[6:0] >= RUN_CUR_MIN)
                    && (req.wdata[6:0] <= RUN_CUR_MAX) && (req.wdata[DATA_W-1:7] == '0);

  // Parameters; both settings are saved as soon as written
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      run_current_percent  <= RUN_CUR_DEF;
      current_off_polarity <= POLARITY_DEF;
      profile              <= '0;
      motion_target        <= '0;
      motion_remain        <= '0;
    end else if (erase_params) begin
      run_current_percent  <= RUN_CUR_DEF;
      current_off_polarity <= POLARITY_DEF;
      profile              <= '0;
      motion_target        <= '0;
      motion_remain        <= '0;
    end else if (req.wr) begin
      if (run_cur_ok) begin
        run_current_percent <= req.wdata[6:0];
      end
      if (req.addr == REG_POLARITY) begin
        current_off_polarity <= req.wdata[0];
      end
      if (req.addr == REG_PROFILE) begin
        profile <= {req.wdata, req.wdata};
      end
      if (req.addr == REG_MOTION) begin
        motion_target <= req.wdata[POS_W-1:0];
      end
      if (req.addr == REG_REMAIN) begin
        motion_remain <= req.wdata[POS_W-1:0];
      end
    end
  end

  // Stored polarity is copied to the live one only on a reset command;
  // a power cycle brings the default back, matching the saved copy's reset value
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      polarity_active <= POLARITY_DEF;
    end else if (cmd_wr && cmd == CMD_RESET) begin
      polarity_active <= current_off_polarity;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      current_cut   <= 1'b0;
      drive_current <= 7'h00;
    end else begin
      current_cut   <= current_off_input_sync[1] ^ polarity_active;
      drive_current <= (state == ST_MOVING) ? run_current_percent : 7'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      motion_kind <= 3'h0;
      motion_dir  <= 1'b0;
    end else begin
      motion_kind <= cur.kind;
      motion_dir  <= cur.dir;
    end
  end

  // Position table
  genvar gi;
  generate
    for (gi = 0; gi < NUM_POS; gi++) begin : g_pos
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pos_table[gi] <= '0;
        end else if (erase_pos) begin
          pos_table[gi] <= '0;
        end
      end
    end
  endgenerate

  // Sequence directory and copy with overwrite confirmation
  wire [5:0] copy_src = copy_ids[COPY_SRC_LSB +: 6];
  wire [5:0] copy_dst = copy_ids[COPY_DST_LSB - 2 +: 6];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq_present        <= '0;
      copy_ids           <= 12'h000;
      copy_overwrite_ask <= 1'b0;
    end else if (erase_seq) begin
      seq_present        <= '0;
      copy_overwrite_ask <= 1'b0;
    end else if (copy_overwrite_ask && req.wr && req.addr == REG_CONFIRM) begin
      if (key == KEY_YES_UC || key == KEY_YES_LC) begin
        seq_present[copy_dst] <= 1'b1;
      end
      copy_overwrite_ask <= 1'b0;
    end else if (req.wr && req.addr == REG_COPY) begin
      copy_ids <= {req.wdata[COPY_DST_LSB +: 6], req.wdata[COPY_SRC_LSB +: 6]};
    end else if (cmd_wr && cmd == CMD_COPY && seq_present[copy_src]) begin
      if (seq_present[copy_dst]) begin
        copy_overwrite_ask <= 1'b1;
      end else begin
        seq_present[copy_dst] <= 1'b1;
      end
    end
  end

  always_comb begin
    seq_count = '0;
    for (int i = 0; i <= int'(SEQ_ID_MAX); i++) begin
      seq_count = 6'(seq_count + 6'(seq_present[i]));
    end
  end

  // Nonvolatile write strobe and wear counter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nv_write  <= 1'b0;
      nv_writes <= 16'h0000;
    end else begin
      nv_write <= erase_go || run_cur_ok || (req.wr && req.addr == REG_POLARITY);
      if (nv_write) begin
        nv_writes <= nv_writes + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (req.rd) begin
        case (req.addr)
          REG_STATUS:   reg_rdata <= DATA_W'({copy_overwrite_ask, wait_motion_end, seq_running,
                                              resume_blocked, pending_cmd, 5'(state)});
          REG_RUN_CUR:  reg_rdata <= DATA_W'(run_current_percent);
          REG_POLARITY: reg_rdata <= DATA_W'({polarity_active, current_off_polarity});
          REG_MOTION:   reg_rdata <= DATA_W'(cur.target);
          REG_REMAIN:   reg_rdata <= DATA_W'(cur.remain);
          REG_PROFILE:  reg_rdata <= DATA_W'(active_profile[DATA_W-1:0]);
          REG_COPY:     reg_rdata <= DATA_W'({seq_count, copy_ids});
          REG_NV_COUNT: reg_rdata <= DATA_W'(nv_writes);
          default:      reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule

// ### verilog/motion_ctl_pkg.sv
// Shared constants, types and register map for the motion command control block
package motion_ctl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int POS_W  = 24;

  // Register byte offsets
  localparam logic [7:0] REG_CMD        = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_RUN_CUR    = 8'h08;
  localparam logic [7:0] REG_POLARITY   = 8'h0C;
  localparam logic [7:0] REG_MOTION     = 8'h10;
  localparam logic [7:0] REG_REMAIN     = 8'h14;
  localparam logic [7:0] REG_PROFILE    = 8'h18;
  localparam logic [7:0] REG_CONFIRM    = 8'h1C;
  localparam logic [7:0] REG_COPY       = 8'h20;
  localparam logic [7:0] REG_NV_COUNT   = 8'h24;

  // Command codes written to REG_CMD
  localparam logic [3:0] CMD_PAUSE      = 4'h1;
  localparam logic [3:0] CMD_RESUME     = 4'h2;
  localparam logic [3:0] CMD_DISCARD    = 4'h3;
  localparam logic [3:0] CMD_ERASE_ALL  = 4'h4;
  localparam logic [3:0] CMD_ERASE_POS  = 4'h5;
  localparam logic [3:0] CMD_ERASE_SEQ  = 4'h6;
  localparam logic [3:0] CMD_COPY       = 4'h7;
  localparam logic [3:0] CMD_RESET      = 4'h8;
  localparam logic [3:0] CMD_START_MOVE = 4'h9;
  localparam logic [3:0] CMD_MOVE_DONE  = 4'hA;
  localparam logic [3:0] CMD_SEQ_RUN    = 4'hB;
  localparam logic [3:0] CMD_SEQ_STOP   = 4'hC;
  localparam logic [3:0] CMD_WAIT_END   = 4'hD;

  // Confirmation key
  localparam logic [7:0] KEY_YES_UC     = 8'h59;
  localparam logic [7:0] KEY_YES_LC     = 8'h79;

  // Field positions
  localparam int CMD_LSB        = 0;
  localparam int CMD_ARG_LSB    = 8;
  localparam int COPY_SRC_LSB   = 0;
  localparam int COPY_DST_LSB   = 8;

  // Run-current limits and defaults
  localparam logic [6:0] RUN_CUR_MIN  = 7'h05;
  localparam logic [6:0] RUN_CUR_MAX  = 7'h64;
  localparam logic [6:0] RUN_CUR_DEF  = 7'h64;
  localparam logic       POLARITY_DEF = 1'b0;
  localparam logic [5:0] SEQ_ID_MAX   = 6'h3F;

  // Erase timing: sequence erase time scales with count stored
  localparam int ERASE_BASE_CYC = 16;
  localparam int ERASE_PER_SEQ  = 8;

  typedef enum logic [2:0] {
    MOVE_NONE     = 3'b000,
    MOVE_INC      = 3'b001,
    MOVE_ABS      = 3'b010,
    MOVE_RESUME_COMMAND     = 3'b011,
    MOVE_HOME_POS = 3'b100,
    MOVE_HOME_NEG = 3'b101,
    MOVE_LINKED   = 3'b110
  } move_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_MOVING  = 3'b001,
    ST_PAUSED  = 3'b010,
    ST_CONFIRM = 3'b011,
    ST_ERASING = 3'b100
  } ctl_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    move_kind_t        kind;
    logic              dir;
    logic [POS_W-1:0]  target;
    logic [POS_W-1:0]  remain;
  } motion_t;

  typedef struct packed {
    logic [15:0] start_vel;
    logic [15:0] run_vel;
    logic [15:0] accel;
    logic [15:0] decel;
  } profile_t;

endpackage

// ### testbench/motion_engine_model.sv
// Stand-in motion engine: ends each started move after a set time unless stopped
`timescale 1ns/1ns
module motion_engine_model #(
  parameter int FAST = 6,
  parameter int SLOW = 40
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic slow,
  input  wire logic motion_go,
  input  wire logic soft_stop,
  output logic      motion_done
);
  int left;
  always_ff @(posedge ref_clk) begin
    motion_done <= 1'b0;
    if (sys_rst || soft_stop) begin
      // A stopped move never reports an end, so waits stay held
      left <= 0;
    end else if (motion_go) begin
      left <= slow ? SLOW : FAST;
    end else if (left == 1) begin
      motion_done <= 1'b1;
      left        <= 0;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule

// ### testbench/motion_ctl_properties.sv
// Port-level assertions for the motion command control block
`timescale 1ns/1ns
module motion_ctl_properties
  import motion_ctl_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              motion_done,
  input wire logic              motion_go,
  input wire logic              soft_stop,
  input wire logic [6:0]        drive_current,
  input wire logic              nv_write,
  input wire logic              motion_end_release
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic cur_ok;
  assign cur_ok = reg_wr && reg_addr == REG_RUN_CUR && reg_wdata inside {[32'h05:32'h64]};

  current_range_a: assert property (drive_current == 7'h00 || drive_current inside {[7'h05:7'h64]})
    else $error("drive current outside allowed range");
  current_save_a: assert property (cur_ok |-> ##[1:2] nv_write)
    else $error("run current write not saved");
  polarity_save_a: assert property (reg_wr && reg_addr == REG_POLARITY |-> ##[1:2] nv_write)
    else $error("polarity write not saved");
  nv_cause_a: assert property ($rose(nv_write) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("nonvolatile write without a request");
  go_pulse_a: assert property (motion_go |=> !motion_go)
    else $error("move start longer than one cycle");
  stop_pulse_a: assert property (soft_stop |=> !soft_stop)
    else $error("soft stop longer than one cycle");
  run_current_a: assert property (motion_go |-> ##[1:2] drive_current != 7'h00)
    else $error("no run current after move start");
  release_cause_a: assert property (motion_end_release |->
    $past(motion_done) || $past(motion_done, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("wait released without motion end");

  cover property (soft_stop);
  cover property (motion_end_release);
  cover property (nv_write);
endmodule

bind motion_pause_resume_current_ctl motion_ctl_properties props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .motion_done(motion_done), .motion_go(motion_go), .soft_stop(soft_stop),
  .drive_current(drive_current), .nv_write(nv_write), .motion_end_release(motion_end_release)
);

// ### testbench/motion_pause_resume_current_ctl_bench.sv
// Self-checking bench for the motion command control block
`timescale 1ns/1ns
module motion_pause_resume_current_ctl_bench;
  import motion_ctl_pkg::*;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              pause_in = 1'b0;
  logic              start_in = 1'b0;
  logic              current_off_input = 1'b0;
  logic              slow = 1'b1;
  logic [DATA_W-1:0] reg_rdata;
  logic [POS_W-1:0]  motion_target;
  logic [6:0]        drive_current;
  logic [2:0]        motion_kind;
  logic              motion_done, motion_go, motion_dir, soft_stop, current_cut, nv_write, motion_end_release;
  int                fail_count = 0, n_tests = 0, cyc = 0, go_n = 0, stop_n = 0, nv_n = 0, rel_n = 0;

  motion_pause_resume_current_ctl #(.NUM_POS(8)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pause_in(pause_in),
    .start_in(start_in), .current_off_input(current_off_input), .motion_done(motion_done),
    .motion_go(motion_go), .motion_kind(motion_kind), .motion_dir(motion_dir),
    .motion_target(motion_target), .motion_remain(), .soft_stop(soft_stop),
    .drive_current(drive_current), .current_cut(current_cut), .nv_write(nv_write),
    .motion_end_release(motion_end_release)
  );
  motion_engine_model engine (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .motion_go(motion_go),
    .soft_stop(soft_stop), .motion_done(motion_done)
  );

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Pulse counters let the tasks judge one-cycle outputs without racing them
  always @(posedge ref_clk) begin
    go_n += int'(motion_go);
    stop_n += int'(soft_stop);
    nv_n += int'(nv_write);
    rel_n += int'(motion_end_release);
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(d & m, e);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Pin pulses are held four cycles so the two-stage synchroniser sees them
  task automatic pin_pulse(input bit is_start);
    @(posedge ref_clk);
    if (is_start) start_in <= 1'b1;
    else pause_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    start_in <= 1'b0;
    pause_in <= 1'b0;
    wait_cyc(3);
  endtask

  task automatic t_current();
    int n;
    rd_chk(REG_RUN_CUR, 32'h7F, 32'h64);
    rd_chk(REG_POLARITY, 32'h3, 32'h0);
    n = nv_n;
    wr(REG_RUN_CUR, 32'h05);
    wr(REG_RUN_CUR, 32'h04);
    wr(REG_RUN_CUR, 32'h65);
    wait_cyc(2);
    check(32'(nv_n - n), 32'h1);
    rd_chk(REG_RUN_CUR, 32'h7F, 32'h05);
    check(32'(drive_current), 32'h0);
    wr(REG_CMD, 32'h0109);
    wait_cyc(3);
    check(32'(drive_current), 32'h05);
    wr(REG_RUN_CUR, 32'h64);
    wait_cyc(2);
    check(32'(drive_current), 32'h64);
    wait_cyc(50);
    check(32'(drive_current), 32'h0);
  endtask

  task automatic t_resume();
    move_kind_t k[5] = '{MOVE_INC, MOVE_ABS, MOVE_RESUME_COMMAND, MOVE_HOME_POS, MOVE_HOME_NEG};
    int g;
    wr(REG_REMAIN, 32'h55);
    for (int i = 0; i < 5; i++) begin
      wr(REG_MOTION, 32'h1234 + i);
      wr(REG_CMD, {20'h0, i[0], k[i], 8'h09});
      wait_cyc(4);
      pin_pulse(1'b0);
      g = go_n;
      rd_chk(REG_STATUS, 32'h1F, 32'(ST_PAUSED));
      check(32'(motion_kind), 32'(k[i]));
      wr(REG_MOTION, 32'h00AA);
      wr(REG_PROFILE, 32'hA0 + i);
      wr(REG_CMD, 32'(CMD_RESUME));
      wait_cyc(2);
      check(32'(go_n - g), 32'h1);
      check(32'(motion_kind), 32'(k[i]));
      check(32'(motion_dir), 32'(i[0]));
      check(32'(motion_target), 32'h00AA);
      rd_chk(REG_MOTION, 32'hFFFFFF, 32'h1234 + i);
      rd_chk(REG_PROFILE, 32'hFFFFFFFF, 32'hA0 + i);
      rd_chk(REG_REMAIN, 32'hFFFFFF, (k[i] == MOVE_HOME_POS || k[i] == MOVE_HOME_NEG) ? 32'h0 : 32'h55);
      wait_cyc(45);
    end
  endtask

  task automatic t_ignore();
    int g, s;
    @(posedge ref_clk);
    slow <= 1'b0;
    wr(REG_CMD, 32'h0109);
    wait_cyc(12);
    check(32'(drive_current), 32'h0);
    slow <= 1'b1;
    g = go_n;
    s = stop_n;
    wr(REG_CMD, 32'(CMD_RESUME));
    wait_cyc(3);
    check(32'(go_n - g), 32'h0);
    wr(REG_CMD, 32'h0609);
    wait_cyc(3);
    wr(REG_CMD, 32'(CMD_PAUSE));
    wait_cyc(2);
    check(32'(stop_n - s), 32'h1);
    g = go_n;
    wr(REG_CMD, 32'(CMD_RESUME));
    wait_cyc(3);
    check(32'(go_n - g), 32'h0);
    wr(REG_CMD, 32'(CMD_DISCARD));
    wait_cyc(45);
  endtask

  task automatic t_seq();
    int g, r;
    wr(REG_CMD, 32'(CMD_SEQ_RUN));
    wr(REG_CMD, 32'h0109);
    wr(REG_CMD, 32'(CMD_WAIT_END));
    wr(REG_CMD, 32'(CMD_PAUSE));
    r = rel_n;
    g = go_n;
    wait_cyc(50);
    check(32'(rel_n - r), 32'h0);
    pin_pulse(1'b1);
    check(32'(go_n - g), 32'h1);
    wait_cyc(45);
    check(32'(rel_n - r), 32'h1);
    wr(REG_CMD, 32'(CMD_SEQ_STOP));
  endtask

  task automatic t_erase();
    logic [3:0] c[3] = '{CMD_ERASE_ALL, CMD_ERASE_POS, CMD_ERASE_SEQ};
    logic [31:0] d;
    int n, t0;
    for (int i = 0; i < 3; i++) begin
      wr(REG_RUN_CUR, 32'h20);
      wait_cyc(3);
      n = nv_n;
      wr(REG_CMD, 32'(c[i]));
      rd_chk(REG_STATUS, 32'h1F, 32'(ST_CONFIRM));
      wr(REG_CONFIRM, 32'h4E);
      rd_chk(REG_STATUS, 32'h1F, 32'(ST_IDLE));
      check(32'(nv_n - n), 32'h0);
      wr(REG_CMD, 32'(c[i]));
      wr(REG_CONFIRM, i[0] ? 32'h79 : 32'h59);
      t0 = cyc;
      d = '1;
      for (int w = 0; w < 400 && d[4:0] !== 5'(ST_IDLE); w++) begin
        rd(REG_STATUS, d);
      end
      check(32'(cyc - t0 >= ERASE_BASE_CYC), 32'h1);
      check(32'(nv_n > n), 32'h1);
      rd_chk(REG_RUN_CUR, 32'h7F, i == 0 ? 32'h64 : 32'h20);
    end
  endtask

  task automatic t_polarity();
    wr(REG_POLARITY, 32'h1);
    wait_cyc(4);
    rd_chk(REG_POLARITY, 32'h3, 32'h1);
    check(32'(current_cut), 32'h0);
    wr(REG_CMD, 32'(CMD_RESET));
    wait_cyc(4);
    rd_chk(REG_POLARITY, 32'h3, 32'h3);
    check(32'(current_cut), 32'h1);
    @(posedge ref_clk);
    current_off_input <= 1'b1;
    wait_cyc(5);
    check(32'(current_cut), 32'h0);
    rd_chk(REG_NV_COUNT, 32'hFFFF, 32'(nv_n));
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_current();
    $display("current test done");
    t_resume();
    $display("resume test done");
    t_ignore();
    $display("ignore test done");
    t_seq();
    $display("sequence test done");
    t_erase();
    $display("erase test done");
    t_polarity();
    $display("polarity test done");
    end_sim();
  end
endmodule
